// ### pkg/dcerr_pkg.sv
// Package for the data cache error control and status block
package dcerr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 64;
  // Register word addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_INT_MASK = 4'h2;
  // Control field positions
  localparam int CTL_DATA_CHK = 7;
  localparam int CTL_TAG_CHK = 6;
  localparam int CTL_STALE_CODE = 5;
  localparam int CTL_WRONG_TAG = 4;
  localparam int CTL_FORCE_HIT = 2;
  localparam int CTL_SET_HI = 1;
  localparam int CTL_SET_LO = 0;
  localparam logic [1:0] SET_EN_RESET = 2'h3;
  localparam logic [1:0] SET_EN_NONE = 2'h0;
  // Status field positions
  localparam int ST_SECOND = 4;
  localparam int ST_LOAD = 3;
  localparam int ST_STORE = 2;
  localparam int ST_TAG_P1 = 1;
  localparam int ST_TAG_P0 = 0;
  localparam int ST_W = 5;
  localparam logic [4:0] ST_RESET = 5'h00;
  // Window for a second store error, in cycles
  localparam int SECOND_WINDOW = 6;
  localparam logic [2:0] WIN_MAX = 3'h6;
  localparam logic [2:0] WIN_ZERO = 3'h0;

  // Control fields as carried to the cache
  typedef struct packed {
    logic data_check_enable;
    logic tag_check_enable;
    logic force_stale_data_code;
    logic force_wrong_tag_check;
    logic force_hit;
    logic [1:0] set_enable;
  } dcerr_ctl_s;

  // Error events reported by the cache pipes, one cycle each
  typedef struct packed {
    logic load_single_bit;
    logic store_ecc;
    logic tag_parity_p1;
    logic tag_parity_p0;
  } dcerr_evt_s;
endpackage

// ### rtl/dcerr_top.sv
// Data cache error control and status register block
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dcerr_top (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [3:0] ADDR,
  input wire logic [63:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [63:0] RDATA,
  input wire logic LOAD_ERR_EVT,
  input wire logic STORE_ERR_EVT,
  input wire logic TAG_ERR_P1_EVT,
  input wire logic TAG_ERR_P0_EVT,
  input wire logic TAG_MATCH,
  input wire logic TAG_DIRTY,
  input wire logic FILL_TAG_PARITY,
  input wire logic FILL_TAG_WR,
  input wire logic DATA_CODE_WR,
  output logic DATA_CHECK_EN,
  output logic TAG_CHECK_EN,
  output logic [1:0] SET_ENABLE,
  output logic CACHE_HIT,
  output logic HIT_DIRTY,
  output logic TAG_PARITY_OUT,
  output logic DATA_CODE_WR_EN,
  output logic MACHINE_CHECK,
  output logic IRQ
);

  dcerr_pkg::dcerr_ctl_s ctl_r;
  dcerr_pkg::dcerr_evt_s evt;
  logic [4:0] status_r;
  logic [4:0] mask_r;
  logic [4:0] set_vec;
  logic [4:0] clr_vec;
  logic [2:0] win_r;
  logic second_hit;
  logic wr_ctl;
  logic wr_st;
  logic wr_mask;

  assign evt = '{load_single_bit: LOAD_ERR_EVT, store_ecc: STORE_ERR_EVT,
                 tag_parity_p1: TAG_ERR_P1_EVT, tag_parity_p0: TAG_ERR_P0_EVT};
  assign wr_ctl = WR_STB && (ADDR == dcerr_pkg::ADDR_CONTROL);
  assign wr_st = WR_STB && (ADDR == dcerr_pkg::ADDR_STATUS);
  assign wr_mask = WR_STB && (ADDR == dcerr_pkg::ADDR_INT_MASK);

  // Control register; an all-zero set field is ignored so one set stays live
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_r <= '{data_check_enable: 1'b0, tag_check_enable: 1'b0,
                 force_stale_data_code: 1'b0, force_wrong_tag_check: 1'b0,
                 force_hit: 1'b0, set_enable: dcerr_pkg::SET_EN_RESET};
    end else if (wr_ctl) begin
      ctl_r.data_check_enable <= WDATA[dcerr_pkg::CTL_DATA_CHK];
      ctl_r.tag_check_enable <= WDATA[dcerr_pkg::CTL_TAG_CHK];
      ctl_r.force_stale_data_code <= WDATA[dcerr_pkg::CTL_STALE_CODE];
      ctl_r.force_wrong_tag_check <= WDATA[dcerr_pkg::CTL_WRONG_TAG];
      ctl_r.force_hit <= WDATA[dcerr_pkg::CTL_FORCE_HIT];
      if (WDATA[dcerr_pkg::CTL_SET_HI:dcerr_pkg::CTL_SET_LO] != dcerr_pkg::SET_EN_NONE) begin
        ctl_r.set_enable <= WDATA[dcerr_pkg::CTL_SET_HI:dcerr_pkg::CTL_SET_LO];
      end
    end
  end

  // Control outputs to the cache datapath
  assign DATA_CHECK_EN = ctl_r.data_check_enable;
  assign TAG_CHECK_EN = ctl_r.tag_check_enable;
  assign SET_ENABLE = ctl_r.set_enable;
  assign CACHE_HIT = TAG_MATCH || ctl_r.force_hit;
  assign HIT_DIRTY = TAG_DIRTY; // dirty comes from tags only
  assign TAG_PARITY_OUT = FILL_TAG_PARITY ^ (ctl_r.force_wrong_tag_check && FILL_TAG_WR);
  assign DATA_CODE_WR_EN = DATA_CODE_WR && !ctl_r.force_stale_data_code;

  // Store error window counter; loads with 6 after each enabled store error
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      win_r <= dcerr_pkg::WIN_ZERO;
    end else if (evt.store_ecc && ctl_r.data_check_enable) begin
      win_r <= dcerr_pkg::WIN_MAX;
    end else if (win_r != dcerr_pkg::WIN_ZERO) begin
      win_r <= win_r - 3'h1;
    end
  end
  assign second_hit = evt.store_ecc && ctl_r.data_check_enable && (win_r != dcerr_pkg::WIN_ZERO);

  // Event set vector, gated by the check enables
  always_comb begin
    set_vec = dcerr_pkg::ST_RESET;
    set_vec[dcerr_pkg::ST_SECOND] = second_hit;
    set_vec[dcerr_pkg::ST_LOAD] = evt.load_single_bit && ctl_r.data_check_enable;
    set_vec[dcerr_pkg::ST_STORE] = evt.store_ecc && ctl_r.data_check_enable;
    set_vec[dcerr_pkg::ST_TAG_P1] = evt.tag_parity_p1 && ctl_r.tag_check_enable;
    set_vec[dcerr_pkg::ST_TAG_P0] = evt.tag_parity_p0 && ctl_r.tag_check_enable;
  end
  assign clr_vec = wr_st ? WDATA[dcerr_pkg::ST_W-1:0] : dcerr_pkg::ST_RESET;

  // Sticky flags; a set in the clearing cycle wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < dcerr_pkg::ST_W; gi++) begin : g_flag
      always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
          status_r[gi] <= 1'b0;
        end else if (set_vec[gi]) begin
          status_r[gi] <= 1'b1;
        end else if (clr_vec[gi]) begin
          status_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt mask register
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_r <= dcerr_pkg::ST_RESET;
    end else if (wr_mask) begin
      mask_r <= WDATA[dcerr_pkg::ST_W-1:0];
    end
  end

  assign IRQ = |(status_r & mask_r);
  // Tag parity errors cannot be corrected, so they raise a machine check
  assign MACHINE_CHECK = status_r[dcerr_pkg::ST_TAG_P1] || status_r[dcerr_pkg::ST_TAG_P0];

  // Read data; control is write-only and reads as zero
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 64'h0;
    end else if (RD_STB) begin
      case (ADDR)
        dcerr_pkg::ADDR_STATUS: RDATA <= {59'h0, status_r};
        dcerr_pkg::ADDR_INT_MASK: RDATA <= {59'h0, mask_r};
        default: RDATA <= 64'h0;
      endcase
    end else begin
      RDATA <= 64'h0;
    end
  end

  // Assertions
  // They watch only what this block drives; the cache pipes are trusted to pulse
  // each event for one cycle, which only the second error flag can tell apart from a longer level.
  sequence s_store_err;
    STORE_ERR_EVT && ctl_r.data_check_enable;
  endsequence

  a_force_hit: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    ctl_r.force_hit |-> CACHE_HIT) else $error("forced hit missing");
  a_dirty_pass: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    HIT_DIRTY == TAG_DIRTY) else $error("dirty altered");
  a_stale_code: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    ctl_r.force_stale_data_code |-> !DATA_CODE_WR_EN) else $error("code written");
  a_bad_parity: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (ctl_r.force_wrong_tag_check && FILL_TAG_WR) |-> TAG_PARITY_OUT != FILL_TAG_PARITY)
    else $error("tag parity not inverted");
  a_set_nonzero: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    SET_ENABLE != dcerr_pkg::SET_EN_NONE) else $error("no set enabled");
  a_second_err: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    s_store_err ##[1:6] s_store_err |=> status_r[dcerr_pkg::ST_SECOND])
    else $error("second error missed");
  a_store_err: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    s_store_err |=> status_r[dcerr_pkg::ST_STORE]) else $error("store flag not set");
  a_load_err: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (LOAD_ERR_EVT && ctl_r.data_check_enable) |=> status_r[dcerr_pkg::ST_LOAD])
    else $error("load flag");
  a_tag_p1: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (TAG_ERR_P1_EVT && ctl_r.tag_check_enable) |=> status_r[dcerr_pkg::ST_TAG_P1] && MACHINE_CHECK)
    else $error("pipe one tag flag");
  a_tag_p0: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (TAG_ERR_P0_EVT && ctl_r.tag_check_enable) |=> status_r[dcerr_pkg::ST_TAG_P0] && MACHINE_CHECK)
    else $error("pipe zero tag flag");
  a_w1c_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (wr_st && WDATA[dcerr_pkg::ST_STORE] && !set_vec[dcerr_pkg::ST_STORE])
    |=> !status_r[dcerr_pkg::ST_STORE]) else $error("clear failed");
  a_data_chk_en: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    wr_ctl |=> DATA_CHECK_EN == $past(WDATA[dcerr_pkg::CTL_DATA_CHK]))
    else $error("data check enable");
  a_tag_chk_en: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    wr_ctl |=> TAG_CHECK_EN == $past(WDATA[dcerr_pkg::CTL_TAG_CHK]))
    else $error("tag check enable");
  a_status_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (status_r[dcerr_pkg::ST_TAG_P0] && !clr_vec[dcerr_pkg::ST_TAG_P0])
    |=> status_r[dcerr_pkg::ST_TAG_P0]) else $error("flag lost");
  a_reset_vals: assert property (@(posedge CORE_CLK)
    $rose(RST_B) |-> status_r == dcerr_pkg::ST_RESET && SET_ENABLE == dcerr_pkg::SET_EN_RESET)
    else $error("reset values");
  a_ctl_read: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (RD_STB && ADDR == dcerr_pkg::ADDR_CONTROL) |=> RDATA == '0) else $error("control readable");

  // Enabled store error as a plain boolean, so sequences can negate it
  logic store_taken;
  assign store_taken = evt.store_ecc && ctl_r.data_check_enable;

  // A store error and then six quiet cycles: the next error is one cycle too late
  // to pair, which pins the far end of the window and not only the near end
  sequence s_lone_store;
    store_taken ##1 (!store_taken) [*6];
  endsequence

  // The late error arrives while the second flag is still clear
  sequence s_late_store;
    store_taken && !status_r[dcerr_pkg::ST_SECOND];
  endsequence

  // Window end: an error seven cycles after the last one does not pair
  a_gap_seven: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    s_lone_store ##1 s_late_store |=> !status_r[dcerr_pkg::ST_SECOND])
    else $error("late error paired");

  // Window counter reloads on every enabled store error
  a_window_load: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    store_taken |=> win_r == dcerr_pkg::WIN_MAX) else $error("window not loaded");

  // Window counter never passes its full length
  a_window_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    win_r <= dcerr_pkg::WIN_MAX) else $error("window out of range");

  // Stale data code bit lands on a write
  a_stale_wr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    wr_ctl |=> ctl_r.force_stale_data_code == $past(WDATA[dcerr_pkg::CTL_STALE_CODE]))
    else $error("stale code bit not written");

  // Wrong tag parity bit lands on a write
  a_wrong_wr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    wr_ctl |=> ctl_r.force_wrong_tag_check == $past(WDATA[dcerr_pkg::CTL_WRONG_TAG]))
    else $error("wrong parity bit not written");

  // Forced hit bit lands on a write
  a_hit_wr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    wr_ctl |=> ctl_r.force_hit == $past(WDATA[dcerr_pkg::CTL_FORCE_HIT]))
    else $error("forced hit bit not written");

  // A set field with at least one set enabled is taken as written
  a_set_wr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (wr_ctl && WDATA[dcerr_pkg::CTL_SET_HI:dcerr_pkg::CTL_SET_LO] != dcerr_pkg::SET_EN_NONE)
    |=> SET_ENABLE == $past(WDATA[dcerr_pkg::CTL_SET_HI:dcerr_pkg::CTL_SET_LO]))
    else $error("set field not written");

  // An empty set field is dropped, so the cache never loses every set
  a_set_keep: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (wr_ctl && WDATA[dcerr_pkg::CTL_SET_HI:dcerr_pkg::CTL_SET_LO] == dcerr_pkg::SET_EN_NONE)
    |=> $stable(SET_ENABLE)) else $error("empty set field taken");

  // Control only changes on a control write
  a_ctl_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !wr_ctl |=> $stable(ctl_r)) else $error("control changed unasked");

  // Without forced hit the compare result passes through
  a_hit_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !ctl_r.force_hit |-> CACHE_HIT == TAG_MATCH) else $error("hit altered");

  // Without the stale code mode the check code write passes through
  a_code_pass: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !ctl_r.force_stale_data_code |-> DATA_CODE_WR_EN == DATA_CODE_WR)
    else $error("code write altered");

  // Tag parity is only spoiled on a fill while the mode is on
  a_parity_pass: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !(ctl_r.force_wrong_tag_check && FILL_TAG_WR) |-> TAG_PARITY_OUT == FILL_TAG_PARITY)
    else $error("tag parity altered");

  // Events arriving with their check disabled leave a clear flag clear
  a_load_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (LOAD_ERR_EVT && !ctl_r.data_check_enable && !status_r[dcerr_pkg::ST_LOAD])
    |=> !status_r[dcerr_pkg::ST_LOAD]) else $error("load flag while disabled");

  // Store errors are ignored while data checking is off
  a_store_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (STORE_ERR_EVT && !ctl_r.data_check_enable && !status_r[dcerr_pkg::ST_STORE])
    |=> !status_r[dcerr_pkg::ST_STORE]) else $error("store flag while disabled");

  // Pipe one tag errors are ignored while tag checking is off
  a_p1_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (TAG_ERR_P1_EVT && !ctl_r.tag_check_enable && !status_r[dcerr_pkg::ST_TAG_P1])
    |=> !status_r[dcerr_pkg::ST_TAG_P1]) else $error("pipe one flag while disabled");

  // Pipe zero tag errors are ignored while tag checking is off
  a_p0_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (TAG_ERR_P0_EVT && !ctl_r.tag_check_enable && !status_r[dcerr_pkg::ST_TAG_P0])
    |=> !status_r[dcerr_pkg::ST_TAG_P0]) else $error("pipe zero flag while disabled");

  // Writing one clears each remaining flag when no event sets it again
  a_load_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (wr_st && WDATA[dcerr_pkg::ST_LOAD] && !set_vec[dcerr_pkg::ST_LOAD])
    |=> !status_r[dcerr_pkg::ST_LOAD]) else $error("load flag not cleared");
  a_p1_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (wr_st && WDATA[dcerr_pkg::ST_TAG_P1] && !set_vec[dcerr_pkg::ST_TAG_P1])
    |=> !status_r[dcerr_pkg::ST_TAG_P1]) else $error("pipe one flag not cleared");
  a_p0_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (wr_st && WDATA[dcerr_pkg::ST_TAG_P0] && !set_vec[dcerr_pkg::ST_TAG_P0])
    |=> !status_r[dcerr_pkg::ST_TAG_P0]) else $error("pipe zero flag not cleared");
  a_second_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (wr_st && WDATA[dcerr_pkg::ST_SECOND] && !set_vec[dcerr_pkg::ST_SECOND])
    |=> !status_r[dcerr_pkg::ST_SECOND]) else $error("second flag not cleared");

  // An event in the clearing cycle wins, so software never loses an error
  a_set_wins: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (wr_st && WDATA[dcerr_pkg::ST_STORE] && store_taken) |=> status_r[dcerr_pkg::ST_STORE])
    else $error("clear beat the event");

  // Flags hold until cleared
  a_load_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (status_r[dcerr_pkg::ST_LOAD] && !clr_vec[dcerr_pkg::ST_LOAD])
    |=> status_r[dcerr_pkg::ST_LOAD]) else $error("load flag lost");
  a_store_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (status_r[dcerr_pkg::ST_STORE] && !clr_vec[dcerr_pkg::ST_STORE])
    |=> status_r[dcerr_pkg::ST_STORE]) else $error("store flag lost");
  a_p1_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (status_r[dcerr_pkg::ST_TAG_P1] && !clr_vec[dcerr_pkg::ST_TAG_P1])
    |=> status_r[dcerr_pkg::ST_TAG_P1]) else $error("pipe one flag lost");
  a_second_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (status_r[dcerr_pkg::ST_SECOND] && !clr_vec[dcerr_pkg::ST_SECOND])
    |=> status_r[dcerr_pkg::ST_SECOND]) else $error("second flag lost");

  // No flag rises without an enabled event
  a_no_spurious: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (status_r == dcerr_pkg::ST_RESET && set_vec == dcerr_pkg::ST_RESET)
    |=> status_r == dcerr_pkg::ST_RESET) else $error("flag rose unasked");

  // Machine check only from a tag parity flag
  a_mc_source: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    MACHINE_CHECK |-> status_r[dcerr_pkg::ST_TAG_P1] || status_r[dcerr_pkg::ST_TAG_P0])
    else $error("machine check without tag flag");

  // Mask register takes its write
  a_mask_wr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    wr_mask |=> mask_r == $past(WDATA[dcerr_pkg::ST_W-1:0])) else $error("mask not written");

  // A fully masked block never interrupts
  a_irq_masked: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    mask_r == dcerr_pkg::ST_RESET |-> !IRQ) else $error("masked interrupt");

  // Status read returns the flags of the strobe cycle
  a_read_status: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (RD_STB && ADDR == dcerr_pkg::ADDR_STATUS) |=> RDATA == 64'($past(status_r)))
    else $error("status read wrong");

  // Read data stand one cycle only, zero otherwise
  a_read_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !RD_STB |=> RDATA == '0) else $error("read data lingered");

  // Control fields start cleared apart from the set field
  a_reset_ctl: assert property (@(posedge CORE_CLK)
    $rose(RST_B) |-> !DATA_CHECK_EN && !TAG_CHECK_EN && !ctl_r.force_hit)
    else $error("control reset values");

endmodule
`default_nettype wire

// ### verification/dcerr_top_test.sv
// Self-checking testbench for the data cache error control and status block
`timescale 1ns/1ps
`default_nettype none
module dcerr_top_test;
  logic clk, rst_b, wr, rd, look, rd_d;
  logic [3:0] addr, evt;
  logic [4:0] dp, st, msk;
  logic [7:0] ctl;
  logic [63:0] wdata;
  logic [63:0] q[$];
  wire [63:0] rdata;
  wire [9:0] outs;
  int fails, comparisons;

  dcerr_top dut (.CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR_STB(wr),
    .RD_STB(rd), .RDATA(rdata), .LOAD_ERR_EVT(evt[3]), .STORE_ERR_EVT(evt[2]),
    .TAG_ERR_P1_EVT(evt[1]), .TAG_ERR_P0_EVT(evt[0]), .TAG_MATCH(dp[4]), .TAG_DIRTY(dp[3]),
    .FILL_TAG_PARITY(dp[2]), .FILL_TAG_WR(dp[1]), .DATA_CODE_WR(dp[0]),
    .DATA_CHECK_EN(outs[9]), .TAG_CHECK_EN(outs[8]), .SET_ENABLE(outs[7:6]),
    .CACHE_HIT(outs[5]), .HIT_DIRTY(outs[4]), .TAG_PARITY_OUT(outs[3]),
    .DATA_CODE_WR_EN(outs[2]), .MACHINE_CHECK(outs[1]), .IRQ(outs[0]));

  // Free-running core clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Read data stand only in the cycle after the strobe, so note which cycle that is
  always @(posedge clk) rd_d <= rd;

  // Take the oldest note off the queue whenever read data or a port sample is due
  always @(negedge clk) begin
    if (rd_d || look) begin
      comparisons++;
      if (q.size() == 0 || (rd_d ? rdata : {54'h0, outs}) !== q[0]) begin
        fails++;
        $display("[ERR] %0t %s mismatch", $time, rd_d ? "read" : "port");
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end

  task automatic wreg(input logic [3:0] a, input logic [63:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [63:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 4'h0;
  endtask

  // Expected port vector is built from the bench's own copy of control, status and mask
  task automatic sample();
    @(posedge clk);
    look <= 1'b1;
    q.push_back({54'h0, ctl[7:6], ctl[1:0], dp[4] | ctl[2], dp[3], dp[2] ^ (ctl[4] & dp[1]),
      dp[0] & ~ctl[5], |st[1:0], |(st & msk)});
    @(posedge clk);
    look <= 1'b0;
  endtask

  task automatic conclude();
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    rst_b = 1'b0;
    {wr, rd, look, rd_d, addr, wdata, evt, dp} = '0;
    ctl = 8'h03;
    st = 5'h00;
    msk = 5'h00;
    fails = 0;
    comparisons = 0;
    void'($urandom(32'h1BB5));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    sample();
    rreg(4'h1, 64'h0);
    pulse(4'hF);
    rreg(4'h1, 64'h0);
    ctl = 8'hC3;
    wreg(4'h0, {$urandom, $urandom} & 64'hFFFF_FFFF_FFFF_FF00 | 64'hC3);
    rreg(4'h0, 64'h0);
    wreg(4'h2, 64'h1F);
    msk = 5'h1F;
    sample();
    // Event bit order matches status bit order for the four direct flags
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i);
      st[i] = 1'b1;
      rreg(4'h1, {59'h0, st});
      sample();
    end
    wreg(4'h1, 64'h0);
    rreg(4'h1, {59'h0, st});
    for (int i = 0; i < 4; i++) begin
      wreg(4'h1, 64'h1 << i);
      st[i] = 1'b0;
      rreg(4'h1, {59'h0, st});
      sample();
    end
    // Masked event keeps the interrupt low but still raises the machine check
    wreg(4'h2, 64'h0);
    msk = 5'h00;
    pulse(4'h1);
    st = 5'h01;
    sample();
    wreg(4'h1, 64'h1F);
    st = 5'h00;
    // Gap of 6 is the last one that pairs, 7 must not
    for (int g = 6; g < 8; g++) begin
      pulse(4'h4);
      repeat (g - 2) @(posedge clk);
      pulse(4'h4);
      rreg(4'h1, {59'h0, g == 6, 4'h4});
      wreg(4'h1, 64'h1F);
      repeat (8) @(posedge clk);
    end
    // Normal mode first, then diagnostic modes with one set enabled and tag check off
    for (int k = 0; k < 2; k++) begin
      ctl = k ? 8'hB5 : 8'hC3;
      wreg(4'h0, {56'h0, ctl});
      for (int j = 0; j < 6; j++) begin
        dp <= 5'($urandom);
        sample();
      end
    end
    wreg(4'h0, 64'h80);
    ctl = 8'h81;
    sample();
    wreg(4'h7, 64'h1F);
    rreg(4'h7, 64'h0);
    rreg(4'h1, 64'h0);
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire
